// ### logic/mie_pkg.sv
// Purpose: constants for the metering interrupt enable block
// Assumes: special function register port of the on-chip core, 8-bit data
// Notes:   addresses are byte addresses of the register space
`default_nettype none
package mie_pkg;
	// special function register addresses
	localparam logic [7:0] ADDR_EN_LOW     = 8'hD9;
	localparam logic [7:0] ADDR_EN_MID     = 8'hDA;
	localparam logic [7:0] ADDR_EN_HIGH    = 8'hDB;
	localparam logic [7:0] ADDR_ST_LOW     = 8'hDC;
	localparam logic [7:0] ADDR_ST_MID     = 8'hDD;
	localparam logic [7:0] ADDR_ST_HIGH    = 8'hDE;
	localparam logic [7:0] ADDR_WAVE_FIRST = 8'hE2;
	localparam logic [7:0] ADDR_WAVE_LAST  = 8'hE7;
	localparam logic [7:0] ADDR_WAVE_VOLT  = 8'hE5;
	// implemented bits; reserved bits read as zero
	localparam logic [7:0] EN_LOW_MASK     = 8'h3F;
	localparam logic [7:0] EN_MID_MASK     = 8'hFF;
	localparam logic [7:0] EN_HIGH_MASK    = 8'h3F;
	localparam logic [7:0] EN_RESET        = 8'h00;
	localparam logic [7:0] ST_RESET        = 8'h00;
	// field positions
	localparam int ST_SUMMARY_BIT  = 7;
	localparam int ST_RESET_BIT    = 7;
	localparam int WAVE_READY_BIT  = 5;
	localparam int PULSE2_BIT      = 7;
	localparam int PULSE1_BIT      = 6;
	localparam int GAIN_CUR_LSB    = 0;
	localparam int GAIN_RANGE_LSB  = 3;
	localparam int GAIN_VOLT_LSB   = 5;
	localparam int GAIN_FIELD_W    = 3;
	localparam int GAIN_RANGE_W    = 2;
	localparam logic [2:0] GAIN_MAX_CODE = 3'h4;
	// converter timing: modulator clock is the master clock over five
	localparam int MOD_CLK_DIV     = 5;
	localparam logic [2:0] MOD_DIV_LAST = 3'h4;
	localparam int SAMPLE_W        = 24;
	localparam int DECIM_LOG       = 5;
endpackage
`default_nettype wire

// ### logic/mie_decim.sv
// Purpose: decimating low-pass filter for one modulator bit stream
// Assumes: strobe_i marks each modulator sample; bit_i already synchronised
// Notes:   box-car average of 2**LOG bits, scaled into a signed W-bit word
`timescale 1ns/10ps
`default_nettype none
module mie_decim #(
	parameter int LOG = 5,
	parameter int W   = 24
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic         clr_i,
	input  wire logic         strobe_i,
	input  wire logic         bit_i,
	output logic [W-1:0]      data_o,
	output logic              valid_o
);
	logic [LOG:0]   ones_r,  ones_nxt;
	logic [LOG-1:0] cnt_r,   cnt_nxt;
	logic [W-1:0]   data_r,  data_nxt;
	logic           valid_r, valid_nxt;
	logic [LOG:0]   ones_tot;
	logic [LOG+1:0] diff;

	// count ones over a window, emit twos-complement average at window end
	always_comb begin
		ones_tot  = ones_r + {{LOG{1'b0}}, bit_i};
		diff      = {ones_tot, 1'b0} - (LOG+2)'(1 << LOG);
		ones_nxt  = ones_r;
		cnt_nxt   = cnt_r;
		data_nxt  = data_r;
		valid_nxt = 1'b0;
		if (clr_i) begin
			ones_nxt = '0;
			cnt_nxt  = '0;
		end else if (strobe_i) begin
			cnt_nxt = cnt_r + 1'b1;
			if (&cnt_r) begin
				data_nxt  = {diff, {(W-LOG-2){1'b0}}};
				valid_nxt = 1'b1;
				ones_nxt  = '0;
			end else begin
				ones_nxt = ones_tot;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ones_r  <= '0;
			cnt_r   <= '0;
			data_r  <= '0;
			valid_r <= 1'b0;
		end else begin
			ones_r  <= ones_nxt;
			cnt_r   <= cnt_nxt;
			data_r  <= data_nxt;
			valid_r <= valid_nxt;
		end
	end

	assign data_o  = data_r;
	assign valid_o = valid_r;
endmodule
`default_nettype wire

// ### logic/mie_top.sv
// Purpose: metering interrupt enables, status flags and converter control
// Assumes: core special function register port on clk_i; events on clk_i
// Notes:   modulator bits come from the analog side and are synchronised
`timescale 1ns/10ps
`default_nettype none
module mie_top
	import mie_pkg::*;
#(
	parameter int DLOG = DECIM_LOG
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic [7:0]  sfr_addr_i,
	input  wire logic [7:0]  sfr_wdata_i,
	input  wire logic        sfr_wr_i,
	input  wire logic        sfr_rd_i,
	output logic [7:0]       sfr_rdata_o,
	input  wire logic [5:0]  evt_low_i,
	input  wire logic [7:0]  evt_mid_i,
	input  wire logic [4:0]  evt_high_i,
	input  wire logic [7:0]  gain_cfg_i,
	input  wire logic        battery_power_mode_i,
	input  wire logic        sleep_power_mode_i,
	input  wire logic        cur_mod_bit_i,
	input  wire logic        volt_mod_bit_i,
	output logic             irq_o,
	output logic             adc_power_down_o,
	output logic             mod_strobe_o,
	output logic [2:0]       cur_gain_o,
	output logic [2:0]       volt_gain_o,
	output logic [1:0]       cur_range_o,
	output logic [23:0]      cur_sample_o,
	output logic [23:0]      volt_sample_o,
	output logic             sample_valid_o
);
	logic [7:0] en_low_r,  en_low_nxt;
	logic [7:0] en_mid_r,  en_mid_nxt;
	logic [7:0] en_high_r, en_high_nxt;
	logic [7:0] st_low_r,  st_low_nxt;
	logic [7:0] st_mid_r,  st_mid_nxt;
	logic [7:0] st_high_r, st_high_nxt;
	logic       irq_r,     irq_nxt;
	logic [7:0] rdata_r,   rdata_nxt;
	logic       rst_d_r;
	logic       pending;
	logic [7:0] set_low, set_mid, set_high;
	logic [2:0] div_r,     div_nxt;
	logic       strobe_r,  strobe_nxt;
	logic       pd_r,      pd_nxt;
	logic [2:0] cgain_r,   cgain_nxt;
	logic [2:0] vgain_r,   vgain_nxt;
	logic [1:0] range_r,   range_nxt;
	logic       cur_s1_r,  cur_s2_r;
	logic       volt_s1_r, volt_s2_r;
	logic [SAMPLE_W-1:0] cur_data, volt_data;
	logic       cur_valid, volt_valid;
	logic [2:0] wave_idx;

	// clamp a gain code to the largest legal setting (x16)
	function automatic logic [2:0] clamp_gain(input logic [2:0] code);
		clamp_gain = (code > GAIN_MAX_CODE) ? GAIN_MAX_CODE : code;
	endfunction

	// enable registers: software written, reserved bits masked to zero
	always_comb begin
		en_low_nxt  = en_low_r;
		en_mid_nxt  = en_mid_r;
		en_high_nxt = en_high_r;
		if (sfr_wr_i) begin
			case (sfr_addr_i)
				ADDR_EN_LOW:  en_low_nxt  = sfr_wdata_i & EN_LOW_MASK;
				ADDR_EN_MID:  en_mid_nxt  = sfr_wdata_i & EN_MID_MASK;
				ADDR_EN_HIGH: en_high_nxt = sfr_wdata_i & EN_HIGH_MASK;
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_low_r  <= EN_RESET;
			en_mid_r  <= EN_RESET;
			en_high_r <= EN_RESET;
		end else begin
			en_low_r  <= en_low_nxt;
			en_mid_r  <= en_mid_nxt;
			en_high_r <= en_high_nxt;
		end
	end

	// event sets: pulse flags set regardless of any pulse output enable
	always_comb begin
		set_low  = {2'b00, evt_low_i};
		set_mid  = evt_mid_i;
		set_high = {rst_d_r, 1'b0, cur_valid, evt_high_i}; // end of reset, waveform ready, events
	end

	// status flags: writing zero clears a bit, a same-cycle event wins
	always_comb begin
		st_low_nxt  = st_low_r;
		st_mid_nxt  = st_mid_r;
		st_high_nxt = st_high_r;
		if (sfr_wr_i) begin
			case (sfr_addr_i)
				ADDR_ST_LOW:  st_low_nxt  = st_low_r & sfr_wdata_i;
				ADDR_ST_MID:  st_mid_nxt  = st_mid_r & sfr_wdata_i;
				ADDR_ST_HIGH: st_high_nxt = st_high_r & sfr_wdata_i;
				default: ;
			endcase
		end
		st_low_nxt  = (st_low_nxt | set_low) & EN_LOW_MASK;
		st_mid_nxt  = st_mid_nxt | set_mid;
		st_high_nxt = (st_high_nxt | set_high) & {1'b1, 1'b0, EN_HIGH_MASK[5:0]};
	end

	// pending request is the OR of every flag gated by its enable
	always_comb begin
		pending = |(st_low_r & en_low_r)
		        | |(st_mid_r & en_mid_r)
		        | |(st_high_r & en_high_r);
		irq_nxt = pending;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			st_low_r  <= ST_RESET;
			st_mid_r  <= ST_RESET;
			st_high_r <= ST_RESET;
			irq_r     <= 1'b0;
			rst_d_r   <= 1'b1;
		end else begin
			st_low_r  <= st_low_nxt;
			st_mid_r  <= st_mid_nxt;
			st_high_r <= st_high_nxt;
			irq_r     <= irq_nxt;
			rst_d_r   <= 1'b0;
		end
	end

	// read mux: summary bit reflects pending, waveform bytes mapped low first
	always_comb begin
		wave_idx  = 3'(sfr_addr_i - ADDR_WAVE_FIRST);
		rdata_nxt = rdata_r;
		if (sfr_rd_i) begin
			rdata_nxt = 8'h00;
			case (sfr_addr_i)
				ADDR_EN_LOW:  rdata_nxt = en_low_r;
				ADDR_EN_MID:  rdata_nxt = en_mid_r;
				ADDR_EN_HIGH: rdata_nxt = en_high_r;
				ADDR_ST_LOW:  rdata_nxt = {pending, st_low_r[6:0]};
				ADDR_ST_MID:  rdata_nxt = st_mid_r;
				ADDR_ST_HIGH: rdata_nxt = st_high_r;
				default: begin
					if (sfr_addr_i >= ADDR_WAVE_FIRST && sfr_addr_i <= ADDR_WAVE_LAST) begin
						if (sfr_addr_i < ADDR_WAVE_VOLT)
							rdata_nxt = cur_sample_o[wave_idx*8 +: 8];
						else
							rdata_nxt = volt_sample_o[(wave_idx-3'h3)*8 +: 8];
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i)
			rdata_r <= 8'h00;
		else
			rdata_r <= rdata_nxt;
	end

	// modulator clock divider and converter power-down
	always_comb begin
		pd_nxt     = battery_power_mode_i | sleep_power_mode_i;
		div_nxt    = div_r;
		strobe_nxt = 1'b0;
		if (pd_r) begin
			div_nxt = 3'h0;
		end else if (div_r == MOD_DIV_LAST) begin
			div_nxt    = 3'h0;
			strobe_nxt = 1'b1;
		end else begin
			div_nxt = div_r + 3'h1;
		end
	end

	// gain fields decoded into shift codes and the current input range
	always_comb begin
		cgain_nxt = clamp_gain(gain_cfg_i[GAIN_CUR_LSB +: GAIN_FIELD_W]);
		vgain_nxt = clamp_gain(gain_cfg_i[GAIN_VOLT_LSB +: GAIN_FIELD_W]);
		range_nxt = gain_cfg_i[GAIN_RANGE_LSB +: GAIN_RANGE_W];
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			div_r    <= 3'h0;
			strobe_r <= 1'b0;
			pd_r     <= 1'b1;
			cgain_r  <= 3'h0;
			vgain_r  <= 3'h0;
			range_r  <= 2'h0;
		end else begin
			div_r    <= div_nxt;
			strobe_r <= strobe_nxt;
			pd_r     <= pd_nxt;
			cgain_r  <= cgain_nxt;
			vgain_r  <= vgain_nxt;
			range_r  <= range_nxt;
		end
	end

	// two-stage synchronisers for the analog modulator bit streams
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cur_s1_r  <= 1'b0;
			cur_s2_r  <= 1'b0;
			volt_s1_r <= 1'b0;
			volt_s2_r <= 1'b0;
		end else begin
			cur_s1_r  <= cur_mod_bit_i;
			cur_s2_r  <= cur_s1_r;
			volt_s1_r <= volt_mod_bit_i;
			volt_s2_r <= volt_s1_r;
		end
	end

	mie_decim #(.LOG(DLOG), .W(SAMPLE_W)) u_cur_decim (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clr_i    (pd_r),
		.strobe_i (strobe_r),
		.bit_i    (cur_s2_r),
		.data_o   (cur_data),
		.valid_o  (cur_valid)
	);

	mie_decim #(.LOG(DLOG), .W(SAMPLE_W)) u_volt_decim (
		.clk_i    (clk_i),
		.rst_i    (rst_i),
		.clr_i    (pd_r),
		.strobe_i (strobe_r),
		.bit_i    (volt_s2_r),
		.data_o   (volt_data),
		.valid_o  (volt_valid)
	);

	// outputs straight from flip-flops, except sample_valid_o, the AND of both valid flags
	assign sfr_rdata_o      = rdata_r;
	assign irq_o            = irq_r;
	assign adc_power_down_o = pd_r;
	assign mod_strobe_o     = strobe_r;
	assign cur_gain_o       = cgain_r;
	assign volt_gain_o      = vgain_r;
	assign cur_range_o      = range_r;
	assign cur_sample_o     = cur_data;
	assign volt_sample_o    = volt_data;
	assign sample_valid_o   = cur_valid & volt_valid;

	// checks on the interrupt path, converter power-down, strobe spacing and gain clamp
	low_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(evt_low_i[0] && en_low_r[0] && !sfr_wr_i) |-> ##2 irq_o)
		else $error("enabled low flag did not raise interrupt");
	pulse2_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(evt_mid_i[PULSE2_BIT] && en_mid_r[PULSE2_BIT] && !sfr_wr_i) |-> ##2 irq_o)
		else $error("second pulse did not raise interrupt");
	pulse1_gate_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(evt_mid_i[PULSE1_BIT] && en_mid_r[PULSE1_BIT] && !sfr_wr_i) |-> ##2 irq_o)
		else $error("first pulse did not raise interrupt");
	pulse_flag_a: assert property (@(posedge clk_i) disable iff (rst_i)
		evt_mid_i[PULSE1_BIT] |=> st_mid_r[PULSE1_BIT])
		else $error("pulse flag not set");
	masked_quiet_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(en_low_r == 8'h00 && en_mid_r == 8'h00 && en_high_r == 8'h00) |=> !irq_o)
		else $error("interrupt with all sources disabled");
	irq_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(irq_o && !sfr_wr_i && !$past(sfr_wr_i)) |=> irq_o)
		else $error("interrupt dropped without a write");
	reset_clean_a: assert property (@(posedge clk_i)
		$fell(rst_i) |-> (en_low_r == 8'h00 && en_high_r == 8'h00 && !irq_o))
		else $error("enables or interrupt not clear after reset");
	power_down_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(battery_power_mode_i || sleep_power_mode_i) |=> adc_power_down_o ##1 !mod_strobe_o)
		else $error("converters not powered down");
	mod_period_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(mod_strobe_o && !adc_power_down_o) |=> !mod_strobe_o [*4])
		else $error("modulator strobe spacing wrong");
	gain_clamp_a: assert property (@(posedge clk_i) disable iff (rst_i)
		(gain_cfg_i[2:0] == 3'h7) |=> (cur_gain_o == 3'h4))
		else $error("current gain code not clamped");
endmodule
`default_nettype wire

// ### dv/mie_mod_model.sv
// Purpose: modulator bit streams that feed the block's two converters
// Assumes: full-scale positive current input, full-scale negative voltage
// Notes:   streams turn to junk while the converters are powered down
`timescale 1ns/10ps
`default_nettype none
module mie_mod_model (
	input  wire logic clk_i,
	input  wire logic pd_i,
	output logic      cur_bit_o,
	output logic      volt_bit_o
);
	logic tog_r = 1'b0;
	// toggle source for the unpowered state
	always_ff @(posedge clk_i) begin
		tog_r <= ~tog_r;
	end
	// all ones and all zeros give the two full-scale words
	assign cur_bit_o  = pd_i ? tog_r : 1'b1;
	assign volt_bit_o = pd_i ? ~tog_r : 1'b0;
endmodule
`default_nettype wire

// ### dv/testbench.sv
// Purpose: self-checking bench for the metering interrupt enable block
// Assumes: register port timing as handed over, DLOG of 2
// Notes:   events and gains driven by the bench, streams by the model
`timescale 1ns/10ps
`default_nettype none
module testbench;
	import mie_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic [7:0]  addr, wdata, rdata, gain;
	logic        wr, rd, bat, slp, cb, vb, irq, pd, strobe, sv;
	logic [18:0] evt;
	logic [2:0]  cg, vg;
	logic [1:0]  cr;
	logic [23:0] cs, vs;
	int          mismatches = 0;
	int          n_tests = 0;
	int          cycles = 0;

	// clock and hang guard
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 6000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	mie_top #(.DLOG(2)) u_mie_top (.clk_i(clk_i), .rst_i(rst_i), .sfr_addr_i(addr), .sfr_wdata_i(wdata),
		.sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .evt_low_i(evt[5:0]), .evt_mid_i(evt[13:6]),
		.evt_high_i(evt[18:14]), .gain_cfg_i(gain), .battery_power_mode_i(bat), .sleep_power_mode_i(slp),
		.cur_mod_bit_i(cb), .volt_mod_bit_i(vb), .irq_o(irq), .adc_power_down_o(pd), .mod_strobe_o(strobe),
		.cur_gain_o(cg), .volt_gain_o(vg), .cur_range_o(cr), .cur_sample_o(cs), .volt_sample_o(vs),
		.sample_valid_o(sv));
	mie_mod_model u_mie_mod_model (.clk_i(clk_i), .pd_i(pd), .cur_bit_o(cb), .volt_bit_o(vb));

	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic tally_and_finish;
		$display("checks %0d mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask

	// register port write and read, one strobe cycle each
	task automatic sfr_wr(input logic [7:0] a, input logic [7:0] dat);
		@(posedge clk_i);
		addr <= a;
		wdata <= dat;
		wr <= 1'b1;
		@(posedge clk_i);
		wr <= 1'b0;
	endtask
	task automatic sfr_rd(input logic [7:0] a, output logic [7:0] dat);
		@(posedge clk_i);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_i);
		rd <= 1'b0;
		settle(1);
		dat = rdata;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] dat;
		sfr_rd(a, dat);
		check(24'(dat), 24'(exp));
	endtask

	// one-cycle event pulse on status source k
	task automatic pulse(input int k);
		@(posedge clk_i);
		evt <= 19'h1 << k;
		@(posedge clk_i);
		evt <= '0;
	endtask

	task automatic strobes(output int n);
		n = 0;
		repeat (25) begin
			settle(1);
			if (strobe === 1'b1) n++;
		end
	endtask

	task automatic wait_valid;
		int i;
		i = 0;
		settle(1);
		while (sv !== 1'b1 && i < 500) begin
			settle(1);
			i++;
		end
		check(24'(sv), 24'h1);
	endtask

	initial begin
		int k, g, b, n;
		logic [7:0] ea;
		logic [7:0] d;
		{addr, wdata, wr, rd, evt, gain, bat, slp} = '0;
		@(posedge clk_i);
		#1;
		check(24'(pd), 24'h1);
		@(posedge clk_i);
		rst_i <= 1'b0;
		#1;
		check(24'(irq), 24'h0);
		rd_chk(ADDR_ST_HIGH, 8'h80);
		// reset values, reserved bits, unmapped place
		for (g = 0; g < 3; g++) begin
			ea = ADDR_EN_LOW + 8'(g);
			rd_chk(ea, 8'h00);
			sfr_wr(ea, 8'hFF);
			rd_chk(ea, (g == 1) ? 8'hFF : 8'h3F);
			sfr_wr(ea, 8'h00);
		end
		sfr_wr(8'h10, 8'hFF);
		rd_chk(8'h10, 8'h00);
		// every source: enabled raises and holds, cleared drops, disabled stays low
		for (k = 0; k < 19; k++) begin
			g = (k < 6) ? 0 : ((k < 14) ? 1 : 2);
			b = k - ((g == 0) ? 0 : ((g == 1) ? 6 : 14));
			ea = ADDR_EN_LOW + 8'(g);
			sfr_wr(ea, 8'h01 << b);
			pulse(k);
			settle(4);
			check(24'(irq), 24'h1);
			sfr_rd(ea + 8'h03, d);
			check(24'(d & (8'h01 << b)), 24'(8'h01 << b));
			sfr_rd(ADDR_ST_LOW, d);
			check(24'(d[7]), 24'h1);
			sfr_wr(ea + 8'h03, 8'h00);
			settle(3);
			check(24'(irq), 24'h0);
			sfr_rd(ADDR_ST_LOW, d);
			check(24'(d[7]), 24'h0);
			sfr_wr(ea, ~(8'h01 << b) & ((g == 2) ? 8'h1F : 8'hFF));
			pulse(k);
			settle(4);
			check(24'(irq), 24'h0);
			sfr_wr(ea + 8'h03, 8'h00);
			sfr_wr(ea, 8'h00);
		end
		// gain fields with clamp
		for (k = 0; k < 8; k++) begin
			@(posedge clk_i);
			gain <= {3'(k), 2'(k), 3'(k)};
			settle(2);
			check(24'(cg), (k > 4) ? 24'h4 : 24'(k));
			check(24'(vg), (k > 4) ? 24'h4 : 24'(k));
			check(24'(cr), 24'(k & 3));
		end
		// battery, sleep, then running
		for (k = 0; k < 3; k++) begin
			@(posedge clk_i);
			bat <= (k == 0);
			slp <= (k == 1);
			settle(3);
			check(24'(pd), (k < 2) ? 24'h1 : 24'h0);
			strobes(n);
			check(24'(n), (k < 2) ? 24'h0 : 24'h5);
		end
		// converter words and their register map
		wait_valid();
		wait_valid();
		check(cs, 24'h400000);
		check(vs, 24'hC00000);
		for (k = 0; k < 6; k++) begin
			rd_chk(ADDR_WAVE_FIRST + 8'(k), (k == 2) ? 8'h40 : ((k == 5) ? 8'hC0 : 8'h00));
		end
		sfr_rd(ADDR_ST_HIGH, d);
		check(24'(d[5]), 24'h1);
		sfr_wr(ADDR_EN_HIGH, 8'h20);
		settle(3);
		check(24'(irq), 24'h1);
		tally_and_finish();
	end
endmodule
`default_nettype wire
